// file: verilog/ioe_pkg.sv
// Constants for the inclusive-OR execute block: register map, field
// positions, reset values, opcodes and execution phases.
// Assumes a single 100 MHz clock and a synchronous active-low reset.
// How it works
// - Literal OR: accumulator OR immediate into accumulator
// - Literal OR opcode: upper byte 0000 1001
// - Only sign and zero flags change
// - Literal OR: one word, four-phase cycle
// - Register OR opcode: top six bits 000100
// - Destination bit: 0 accumulator, 1 register
// - Register OR: one word, four-phase cycle
`default_nettype none

package ioe_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_INSTR = 8'h00;
  localparam logic [7:0] OFF_ACC = 8'h04;
  localparam logic [7:0] OFF_BANK = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0c;
  localparam logic [7:0] OFF_MADDR = 8'h10;
  localparam logic [7:0] OFF_MDATA = 8'h14;
  localparam logic [7:0] OFF_EXEC = 8'h18;

  // Reset values
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [4:0] STATUS_RST = 5'h00;
  localparam logic [15:0] INSTR_RST = 16'h0000;

  // Status field positions
  localparam int STAT_W = 5;
  localparam int STAT_Z = 2;
  localparam int STAT_N = 4;

  // Exec info field positions
  localparam int EXEC_BUSY = 0;
  localparam int EXEC_ILLEGAL = 1;

  // Instruction word fields
  localparam logic [7:0] OPC_OR_LIT = 8'h09;
  localparam logic [5:0] OPC_OR_REG = 6'h04;
  localparam int INSTR_DEST = 9;
  localparam int INSTR_BANKSEL = 8;

  // Clock cycles per instruction cycle (one per phase)
  localparam int PHASES = 4;

  // Execution phases, one-hot
  typedef enum logic [4:0] {
    PH_IDLE = 5'b00001,
    PH_DECODE = 5'b00010,
    PH_READ = 5'b00100,
    PH_PROC = 5'b01000,
    PH_WRITE = 5'b10000
  } ioe_phase_t;

endpackage : ioe_pkg

`default_nettype wire

// file: verilog/ioe_mem.sv
// Data memory for the inclusive-OR execute block.
// One write port, one read port; read data come from a register, one
// cycle after the address. Synchronous active-low reset clears only the
// read register.
`timescale 1ns/1ps
`default_nettype none

module ioe_mem #(
  parameter int AW = 9,
  parameter int DW = 8
) (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [DW-1:0] wdata_i,
  input wire logic [AW-1:0] raddr_i,
  output logic [DW-1:0] rdata_o
);

  logic [DW-1:0] mem_q [0:(1<<AW)-1];

  // Array write, no reset on the storage itself
  always_ff @(posedge sys_clk_i) begin
    if (we_i) begin
      mem_q[waddr_i] <= wdata_i;
    end
  end

  // Registered read port
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= mem_q[raddr_i];
    end
  end

endmodule // ioe_mem

`default_nettype wire

// file: verilog/ioe_core.sv
// Inclusive-OR execute block: runs the literal-OR and register-OR
// instructions over four phases against an accumulator and a banked
// data memory, with the registers on a plain strobe port.
// Assumes one 100 MHz clock and a synchronous active-low reset.
//
// Decided for this implementation: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module ioe_core #(
  parameter int BANK_W = 1,
  parameter logic [BANK_W-1:0] ACCESS_BANK = '0
) (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic [7:0] bus_addr_i,
  input wire logic [31:0] bus_wdata_i,
  input wire logic bus_wr_i,
  input wire logic bus_rd_i,
  output logic [31:0] bus_rdata_o,
  output logic busy_o
);

  localparam int AW = BANK_W + 8;

  ioe_pkg::ioe_phase_t phase_q;
  ioe_pkg::ioe_phase_t phase_d;
  logic [15:0] instr_q;
  logic [7:0] acc_q;
  logic [BANK_W-1:0] bank_q;
  logic [ioe_pkg::STAT_W-1:0] status_q;
  logic [AW-1:0] maddr_q;
  logic [7:0] result_q;
  logic illegal_q;
  logic [7:0] mem_rdata;

  // Register select and write qualifiers
  wire idle = (phase_q == ioe_pkg::PH_IDLE);
  wire sel_instr = (bus_addr_i == ioe_pkg::OFF_INSTR);
  wire sel_acc = (bus_addr_i == ioe_pkg::OFF_ACC);
  wire sel_bank = (bus_addr_i == ioe_pkg::OFF_BANK);
  wire sel_status = (bus_addr_i == ioe_pkg::OFF_STATUS);
  wire sel_maddr = (bus_addr_i == ioe_pkg::OFF_MADDR);
  wire sel_mdata = (bus_addr_i == ioe_pkg::OFF_MDATA);
  wire sel_exec = (bus_addr_i == ioe_pkg::OFF_EXEC);
  wire wr_ok = bus_wr_i & idle;  // Writes are ignored while busy
  wire wr_instr = wr_ok & sel_instr;

  // Instruction decode
  wire is_or_lit = (instr_q[15:8] == ioe_pkg::OPC_OR_LIT);
  wire is_or_reg = (instr_q[15:10] == ioe_pkg::OPC_OR_REG);
  wire dest_reg = instr_q[ioe_pkg::INSTR_DEST];
  wire use_bank = instr_q[ioe_pkg::INSTR_BANKSEL];
  // Access bank or bank select register
  wire [BANK_W-1:0] eff_bank = use_bank ? bank_q : ACCESS_BANK;
  wire [AW-1:0] eff_addr = {eff_bank, instr_q[7:0]};
  wire [7:0] operand = is_or_lit ? instr_q[7:0] : mem_rdata;
  wire valid_op = ~illegal_q;

  // Memory port steering: execution takes the read address in the read phase and the write port in the write phase
  wire exec_mem_we = (phase_q == ioe_pkg::PH_WRITE) & valid_op &
                     is_or_reg & dest_reg;
  wire mem_we = exec_mem_we | (wr_ok & sel_mdata);
  wire [AW-1:0] mem_waddr = exec_mem_we ? eff_addr : maddr_q;
  wire [7:0] mem_wdata = exec_mem_we ? result_q : bus_wdata_i[7:0];
  wire [AW-1:0] mem_raddr = (phase_q == ioe_pkg::PH_READ) ? eff_addr
                                                          : maddr_q;

  // Flag values from the result
  wire flag_n = result_q[7];
  wire flag_z = (result_q == 8'h00);

  // Read data selection, unmapped addresses read zero
  wire [31:0] rd_mux =
    sel_instr ? {16'h0000, instr_q} :
    sel_acc ? {24'h000000, acc_q} :
    sel_bank ? {{(32-BANK_W){1'b0}}, bank_q} :
    sel_status ? {{(32-ioe_pkg::STAT_W){1'b0}}, status_q} :
    sel_maddr ? {{(32-AW){1'b0}}, maddr_q} :
    sel_mdata ? {24'h000000, mem_rdata} :
    sel_exec ? {30'h0, illegal_q, busy_o} : 32'h00000000;

  // Phase sequencer: decode, read, process, write
  always_comb begin
    case (phase_q)
      ioe_pkg::PH_IDLE:
        phase_d = wr_instr ? ioe_pkg::PH_DECODE : ioe_pkg::PH_IDLE;
      ioe_pkg::PH_DECODE: phase_d = ioe_pkg::PH_READ;
      ioe_pkg::PH_READ: phase_d = ioe_pkg::PH_PROC;
      ioe_pkg::PH_PROC: phase_d = ioe_pkg::PH_WRITE;
      default: phase_d = ioe_pkg::PH_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      phase_q <= ioe_pkg::PH_IDLE;
      busy_o <= 1'b0;
    end else begin
      phase_q <= phase_d;
      busy_o <= (phase_d != ioe_pkg::PH_IDLE);
    end
  end

  // Instruction word, bank select and memory pointer
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      instr_q <= ioe_pkg::INSTR_RST;
      bank_q <= '0;
      maddr_q <= '0;
    end else begin
      if (wr_instr) instr_q <= bus_wdata_i[15:0];
      if (wr_ok & sel_bank) bank_q <= bus_wdata_i[BANK_W-1:0];
      if (wr_ok & sel_maddr) maddr_q <= bus_wdata_i[AW-1:0];
    end
  end

  // Decode check and processing of the OR result
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      illegal_q <= 1'b0;
      result_q <= 8'h00;
    end else begin
      if (phase_q == ioe_pkg::PH_DECODE) illegal_q <= ~(is_or_lit | is_or_reg);
      if (phase_q == ioe_pkg::PH_PROC) result_q <= acc_q | operand;
    end
  end

  // Accumulator and status: software writes when idle, results at write
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      acc_q <= ioe_pkg::ACC_RST;
      status_q <= ioe_pkg::STATUS_RST;
    end else if (phase_q == ioe_pkg::PH_WRITE) begin
      if (valid_op & (is_or_lit | ~dest_reg)) begin
        acc_q <= result_q;
      end
      if (valid_op) begin
        status_q[ioe_pkg::STAT_N] <= flag_n;
        status_q[ioe_pkg::STAT_Z] <= flag_z;
      end
    end else begin
      if (wr_ok & sel_acc) acc_q <= bus_wdata_i[7:0];
      if (wr_ok & sel_status) status_q <= bus_wdata_i[ioe_pkg::STAT_W-1:0];
    end
  end

  // Read data stand only in the cycle after the read strobe
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      bus_rdata_o <= 32'h00000000;
    end else begin
      bus_rdata_o <= bus_rd_i ? rd_mux : 32'h00000000;
    end
  end

  ioe_mem #(
    .AW(AW),
    .DW(8)
  ) u_mem (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .we_i(mem_we),
    .waddr_i(mem_waddr),
    .wdata_i(mem_wdata),
    .raddr_i(mem_raddr),
    .rdata_o(mem_rdata)
  );

  // Checks on the execution path
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_issue_lit;
    wr_instr && bus_wdata_i[15:8] == ioe_pkg::OPC_OR_LIT;
  endsequence

  sequence s_four_phases;
    phase_q == ioe_pkg::PH_DECODE ##1 phase_q == ioe_pkg::PH_READ ##1
    phase_q == ioe_pkg::PH_PROC ##1 phase_q == ioe_pkg::PH_WRITE;
  endsequence

  a_lit_or_acc: assert property (
    s_issue_lit |-> ##5 acc_q == ($past(acc_q, 5) | $past(bus_wdata_i[7:0], 5)))
    else $error("literal OR left a wrong accumulator");

  a_bad_opcode_keep: assert property (
    wr_instr && bus_wdata_i[15:8] != ioe_pkg::OPC_OR_LIT &&
    bus_wdata_i[15:10] != ioe_pkg::OPC_OR_REG |-> ##5 acc_q == $past(acc_q, 5))
    else $error("unknown opcode changed the accumulator");

  a_phase_order: assert property (
    wr_instr |=> s_four_phases ##1 phase_q == ioe_pkg::PH_IDLE && !busy_o)
    else $error("instruction cycle phases out of order");

  a_other_flags: assert property (
    phase_q == ioe_pkg::PH_WRITE |=> status_q[3] == $past(status_q[3]) &&
    status_q[1:0] == $past(status_q[1:0]))
    else $error("OR disturbed a flag other than sign or zero");

  a_flag_values: assert property (
    phase_q == ioe_pkg::PH_WRITE && valid_op |=>
    status_q[ioe_pkg::STAT_N] == $past(result_q[7]) &&
    status_q[ioe_pkg::STAT_Z] == ($past(result_q) == 8'h00))
    else $error("sign or zero flag wrong after OR");

  a_reg_dest_acc: assert property (
    phase_q == ioe_pkg::PH_WRITE && valid_op && is_or_reg && !dest_reg |->
    !mem_we ##1 acc_q == $past(result_q))
    else $error("register OR missed the accumulator");

  a_reg_dest_mem: assert property (
    phase_q == ioe_pkg::PH_WRITE && valid_op && is_or_reg && dest_reg |->
    mem_we && mem_waddr == {(instr_q[ioe_pkg::INSTR_BANKSEL] ? bank_q :
    ACCESS_BANK), instr_q[7:0]} && mem_wdata == result_q)
    else $error("register OR missed the addressed register");

  a_bank_choice: assert property (
    phase_q == ioe_pkg::PH_READ && is_or_reg |-> mem_raddr[AW-1:8] ==
    (instr_q[ioe_pkg::INSTR_BANKSEL] ? bank_q : ACCESS_BANK))
    else $error("register OR read the wrong bank");

  a_result_or: assert property (
    phase_q == ioe_pkg::PH_PROC && valid_op |=>
    result_q == ($past(acc_q) | $past(operand)))
    else $error("processing phase gave a wrong OR");

endmodule // ioe_core

`default_nettype wire

// file: sim/inclusive_or_execute_test.sv
// Self-checking bench for the inclusive-OR execute block.
// Assumes ioe_pkg and ioe_core are compiled first; one 100 MHz clock.
`timescale 1ns/1ps
`default_nettype none

module inclusive_or_execute_test;
  logic sys_clk_i;
  logic rstn_i;
  logic [7:0] bus_addr_i;
  logic [31:0] bus_wdata_i;
  logic bus_wr_i;
  logic bus_rd_i;
  logic [31:0] bus_rdata_o;
  logic busy_o;
  int mismatches;
  int checks;

  ioe_core #(.BANK_W(1), .ACCESS_BANK(1'b0)) ioe_core_inst (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .bus_addr_i(bus_addr_i),
    .bus_wdata_i(bus_wdata_i),
    .bus_wr_i(bus_wr_i),
    .bus_rd_i(bus_rd_i),
    .bus_rdata_o(bus_rdata_o),
    .busy_o(busy_o)
  );

  // Free-running clock, 10 ns period
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  // Compare one value and count it
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // Print the counts and the verdict, then stop
  task automatic close_out();
    $display("Checks %0d, mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // One-cycle register write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    bus_wr_i <= 1'b1;
    bus_addr_i <= a;
    bus_wdata_i <= d;
    @(posedge sys_clk_i);
    bus_wr_i <= 1'b0;
  endtask

  // One-cycle read; data stand in the following cycle only
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk_i);
    bus_rd_i <= 1'b1;
    bus_addr_i <= a;
    @(posedge sys_clk_i);
    bus_rd_i <= 1'b0;
    #1;
    check(bus_rdata_o, exp);
  endtask

  // Memory access through the pointer and data window
  task automatic poke(input logic [8:0] a, input logic [7:0] d);
    wr(ioe_pkg::OFF_MADDR, {23'h0, a});
    wr(ioe_pkg::OFF_MDATA, {24'h0, d});
  endtask

  task automatic peek(input logic [8:0] a, input logic [7:0] exp);
    wr(ioe_pkg::OFF_MADDR, {23'h0, a});
    rd(ioe_pkg::OFF_MDATA, {24'h0, exp});
  endtask

  // Start an instruction; optionally check four busy cycles
  task automatic run(input logic [15:0] ins, input bit chk);
    wr(ioe_pkg::OFF_INSTR, {16'h0, ins});
    #1;
    for (int i = 0; i <= ioe_pkg::PHASES; i++) begin
      if (chk) check({31'h0, busy_o}, {31'h0, i < ioe_pkg::PHASES});
      @(posedge sys_clk_i);
      #1;
    end
  endtask

  // Expected status: other bits kept, sign and zero from result
  function automatic logic [31:0] st_exp(input logic [4:0] s,
                                         input logic [7:0] r);
    return {27'h0, r[7], s[3], r == 8'h00, s[1:0]};
  endfunction

  // Literal OR from a chosen accumulator and status
  task automatic lit_case(input logic [7:0] a, input logic [7:0] k,
                          input logic [4:0] s);
    wr(ioe_pkg::OFF_ACC, {24'h0, a});
    wr(ioe_pkg::OFF_STATUS, {27'h0, s});
    run({8'h09, k}, 1'b1);
    rd(ioe_pkg::OFF_ACC, {24'h0, a | k});
    rd(ioe_pkg::OFF_STATUS, st_exp(s, a | k));
  endtask

  // Register OR at memory address m holding v
  task automatic reg_case(input logic d, input logic a, input logic [7:0] x,
                          input logic [8:0] m, input logic [7:0] v);
    logic [7:0] r;
    r = x | v;
    wr(ioe_pkg::OFF_ACC, {24'h0, x});
    wr(ioe_pkg::OFF_STATUS, 32'h0000_000b);
    run({6'h04, d, a, m[7:0]}, 1'b1);
    rd(ioe_pkg::OFF_ACC, {24'h0, d ? x : r});
    peek(m, d ? r : v);
    rd(ioe_pkg::OFF_STATUS, st_exp(5'h0b, r));
  endtask

  // Watchdog against a hung handshake
  initial begin
    repeat (5000) @(posedge sys_clk_i);
    mismatches++;
    close_out();
  end

  // Main sequence
  initial begin
    mismatches = 0;
    checks = 0;
    rstn_i = 1'b0;
    bus_addr_i = 8'h00;
    bus_wdata_i = 32'h0;
    bus_wr_i = 1'b0;
    bus_rd_i = 1'b0;
    repeat (6) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    rd(ioe_pkg::OFF_ACC, 32'h0);
    lit_case(8'h9a, 8'h35, 5'h0b);
    lit_case(8'h00, 8'h00, 5'h1f);
    lit_case(8'h00, 8'hff, 5'h00);
    lit_case(8'h7f, 8'h80, 5'h04);
    // Same offset in both banks, bank select pointing at bank 1
    poke(9'h020, 8'h13);
    poke(9'h120, 8'h40);
    wr(ioe_pkg::OFF_BANK, 32'h1);
    reg_case(1'b0, 1'b0, 8'h91, 9'h020, 8'h13);
    reg_case(1'b0, 1'b1, 8'h01, 9'h120, 8'h40);
    reg_case(1'b1, 1'b1, 8'h82, 9'h120, 8'h40);
    reg_case(1'b1, 1'b0, 8'h24, 9'h020, 8'h13);
    // A neighbouring upper byte must not act as literal OR
    wr(ioe_pkg::OFF_ACC, 32'h0000_0011);
    run(16'h0a55, 1'b0);
    rd(ioe_pkg::OFF_ACC, 32'h0000_0011);
    rd(ioe_pkg::OFF_EXEC, 32'h0000_0002);
    close_out();
  end
endmodule // inclusive_or_execute_test

`default_nettype wire
